// File: design/ctm_consts.svh
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

// register addresses
`define CTM_ADDR_CTRL0 3'h0
`define CTM_ADDR_CTRL1 3'h1
`define CTM_ADDR_CNT_LO 3'h2
`define CTM_ADDR_CNT_HI 3'h3
`define CTM_ADDR_DUTY_LO 3'h4
`define CTM_ADDR_DUTY_HI 3'h5

// reset values
`define CTM_CTRL0_RST 8'h00
`define CTM_CTRL1_RST 8'h00
`define CTM_CNT_RST 10'h000
`define CTM_BYTE_ZERO 8'h00

// control zero fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CLK_HI 6
`define CTM_C0_CLK_LO 4
`define CTM_C0_RUN 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0

// control one fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_PIN_HI 5
`define CTM_C1_PIN_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

// counter layout
`define CTM_CNT_MAX 10'h3FF
`define CTM_CNT_ONE 10'h001
`define CTM_PER_ZERO 3'h0

// clock prescaler taps (div 4, div 16, div 64)
`define CTM_DIV4_MASK 6'h03
`define CTM_DIV16_MASK 6'h0F
`define CTM_DIV64_MASK 6'h3F
`define CTM_PRE_ONE 6'h01

`endif

// File: design/ctm_pkg.sv
package ctm_pkg;

   typedef enum logic [2:0] {
      CTM_CLK_SYS_DIV4 = 3'h0,
      CTM_CLK_SYS = 3'h1,
      CTM_CLK_HIGH_DIV16 = 3'h2,
      CTM_CLK_HIGH_DIV64 = 3'h3,
      CTM_CLK_SUB = 3'h4,
      CTM_CLK_RESERVED = 3'h5,
      CTM_CLK_PIN_RISE = 3'h6,
      CTM_CLK_PIN_FALL = 3'h7
   } ctm_clk_sel_t;

   typedef enum logic [1:0] {
      CTM_MODE_COMPARE = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TIMER = 2'h3
   } ctm_mode_t;

   typedef enum logic [1:0] {
      CTM_PIN_NONE = 2'h0,
      CTM_PIN_LOW = 2'h1,
      CTM_PIN_HIGH = 2'h2,
      CTM_PIN_TOGGLE = 2'h3
   } ctm_pin_act_t;

   typedef struct packed {
      logic [7:0] timer_control_zero;
      logic [7:0] timer_control_one;
      logic [9:0] counter;
      logic [9:0] duty_comparator_value;
      logic [7:0] low_buffer;
      logic [7:0] rd_data;
      logic run_prev;
      logic [5:0] pre_sys;
      logic [5:0] pre_high;
      logic [2:0] pin_sync;
      logic [1:0] high_sync;
      logic [1:0] sub_sync;
      logic high_last;
      logic sub_last;
      logic out_level;
      logic duty_match_flag;
      logic period_match_flag;
   } ctm_state_t;

endpackage

// File: design/ctm_timer.sv
// Functional notes
// - low bytes go through one shared buffer
// - duty low write fills buffer only
// - duty high write also loads buffered low
// - high read captures low byte into buffer
// - low read returns the shared buffer
// - ten-bit up-counter with two comparators
// - period compares bits 9..7; duty all bits
// - counter cleared only by run, overflow, match
// - pause bit halts counting, value retained
// - clock select codes; 101 stops counter
// - run off holds; run rising clears counter
// - run rising in compare mode restores initial output level
// - period code k means k*128, zero 1024
// - clear select zero: period match clears
// - period zero: counter clears by overflow
// - mode field: compare, timer/counter; pwm code counts like compare but holds the pin level
// - clear select one: duty match clears
// - every mode except the undefined code (compare, pwm, timer) raises duty and period flags
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ctm_consts.svh"

module ctm_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // clock sources, asynchronous to clk
   input wire logic high_clk_in,
   input wire logic sub_clk_in,
   input wire logic external_clock_pin,
   // output pin and events
   output logic timer_output_pin,
   output logic duty_match_flag,
   output logic period_match_flag
);

   ctm_pkg::ctm_state_t s;
   ctm_pkg::ctm_state_t next_s;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic ctl_bit(input logic [7:0] r, input int idx);
      ctl_bit = r[idx];
   endfunction

   function automatic logic [7:0] hi_byte(input logic [9:0] v);
      hi_byte = {6'h00, v[9:8]};
   endfunction

   logic tick;
   logic pin_rise;
   logic pin_fall;
   logic high_rise;
   logic sub_rise;
   logic run;
   logic pause;
   logic cclr;
   logic [2:0] per;
   logic per_match;
   logic [9:0] cnt_inc;
   logic duty_match;
   logic overflow;
   logic do_clear;
   ctm_pkg::ctm_clk_sel_t csel;
   ctm_pkg::ctm_mode_t mode;
   ctm_pkg::ctm_pin_act_t pact;

   // ------------------------------------------------------------
   // clock source selection
   // ------------------------------------------------------------
   always_comb begin
      csel = ctm_pkg::ctm_clk_sel_t'(s.timer_control_zero[`CTM_C0_CLK_HI:`CTM_C0_CLK_LO]);
      mode = ctm_pkg::ctm_mode_t'(s.timer_control_one[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
      pact = ctm_pkg::ctm_pin_act_t'(s.timer_control_one[`CTM_C1_PIN_HI:`CTM_C1_PIN_LO]);
      run = ctl_bit(s.timer_control_zero, `CTM_C0_RUN);
      pause = ctl_bit(s.timer_control_zero, `CTM_C0_PAUSE);
      cclr = ctl_bit(s.timer_control_one, `CTM_C1_CCLR);
      per = s.timer_control_zero[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
      // only the second and third sync stages are compared
      pin_rise = s.pin_sync[1] & ~s.pin_sync[2];
      pin_fall = ~s.pin_sync[1] & s.pin_sync[2];
      high_rise = s.high_sync[1] & ~s.high_last;
      sub_rise = s.sub_sync[1] & ~s.sub_last;
      tick = 1'b0;
      unique case (csel)
         ctm_pkg::CTM_CLK_SYS_DIV4: tick = ((s.pre_sys & `CTM_DIV4_MASK) == `CTM_DIV4_MASK);
         ctm_pkg::CTM_CLK_SYS: tick = 1'b1;
         ctm_pkg::CTM_CLK_HIGH_DIV16: tick = high_rise &&
            ((s.pre_high & `CTM_DIV16_MASK) == `CTM_DIV16_MASK);
         ctm_pkg::CTM_CLK_HIGH_DIV64: tick = high_rise &&
            (s.pre_high == `CTM_DIV64_MASK);
         ctm_pkg::CTM_CLK_SUB: tick = sub_rise;
         ctm_pkg::CTM_CLK_RESERVED: tick = 1'b0;
         ctm_pkg::CTM_CLK_PIN_RISE: tick = pin_rise;
         ctm_pkg::CTM_CLK_PIN_FALL: tick = pin_fall;
      endcase
   end

   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------
   always_comb begin
      // match on the incremented count, so code k spans exactly k*128 ticks
      cnt_inc = s.counter + `CTM_CNT_ONE;
      per_match = (per != `CTM_PER_ZERO) && (cnt_inc[9:7] == per) &&
         (cnt_inc[6:0] == 7'h00);
      duty_match = (s.counter == s.duty_comparator_value);
      overflow = (s.counter == `CTM_CNT_MAX);
      // period code zero leaves overflow as the only period-side clear
      // duty value zero would pin the counter at zero, so it overflows then
      if (cclr) begin
         do_clear = (s.duty_comparator_value == `CTM_CNT_RST) ? overflow : duty_match;
      end else begin
         do_clear = per_match || overflow;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.rd_data = `CTM_BYTE_ZERO;
      next_s.pin_sync = {s.pin_sync[1:0], external_clock_pin};
      next_s.high_sync = {s.high_sync[0], high_clk_in};
      next_s.sub_sync = {s.sub_sync[0], sub_clk_in};
      next_s.high_last = s.high_sync[1];
      next_s.sub_last = s.sub_sync[1];
      next_s.pre_sys = s.pre_sys + `CTM_PRE_ONE;
      if (high_rise) begin
         next_s.pre_high = s.pre_high + `CTM_PRE_ONE;
      end
      next_s.run_prev = run;

      // counting
      if (run && !s.run_prev) begin
         next_s.counter = `CTM_CNT_RST;
         if (mode == ctm_pkg::CTM_MODE_COMPARE) begin
            next_s.out_level = ctl_bit(s.timer_control_one, `CTM_C1_INIT);
         end
      end else if (run && !pause && tick) begin
         if (do_clear) begin
            next_s.counter = `CTM_CNT_RST;
         end else begin
            next_s.counter = s.counter + `CTM_CNT_ONE;
         end
         if (duty_match && mode == ctm_pkg::CTM_MODE_COMPARE) begin
            unique case (pact)
               ctm_pkg::CTM_PIN_NONE: next_s.out_level = s.out_level;
               ctm_pkg::CTM_PIN_LOW: next_s.out_level = 1'b0;
               ctm_pkg::CTM_PIN_HIGH: next_s.out_level = 1'b1;
               ctm_pkg::CTM_PIN_TOGGLE: next_s.out_level = ~s.out_level;
            endcase
         end
      end

      // event flags, one clk cycle per match
      next_s.duty_match_flag = 1'b0;
      next_s.period_match_flag = 1'b0;
      if (run && s.run_prev && !pause && tick &&
         mode != ctm_pkg::CTM_MODE_UNDEF) begin
         next_s.duty_match_flag = duty_match &&
            !(cclr && s.duty_comparator_value == `CTM_CNT_RST);
         next_s.period_match_flag = !cclr && (per_match || (per == `CTM_PER_ZERO
            && overflow));
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `CTM_ADDR_CTRL0: next_s.timer_control_zero = reg_wdata;
            `CTM_ADDR_CTRL1: next_s.timer_control_one = reg_wdata;
            `CTM_ADDR_DUTY_LO: next_s.low_buffer = reg_wdata;
            `CTM_ADDR_DUTY_HI: begin
               next_s.duty_comparator_value = {reg_wdata[1:0], s.low_buffer};
            end
            default: next_s.low_buffer = s.low_buffer;
         endcase
      end

      // register reads, data one cycle later
      if (reg_rd) begin
         unique case (reg_addr)
            `CTM_ADDR_CTRL0: next_s.rd_data = s.timer_control_zero;
            `CTM_ADDR_CTRL1: next_s.rd_data = s.timer_control_one;
            `CTM_ADDR_CNT_LO: next_s.rd_data = s.low_buffer;
            `CTM_ADDR_DUTY_LO: next_s.rd_data = s.low_buffer;
            `CTM_ADDR_CNT_HI: begin
               next_s.rd_data = hi_byte(s.counter);
               next_s.low_buffer = s.counter[7:0];
            end
            `CTM_ADDR_DUTY_HI: begin
               next_s.rd_data = hi_byte(s.duty_comparator_value);
               next_s.low_buffer = s.duty_comparator_value[7:0];
            end
            default: next_s.rd_data = `CTM_BYTE_ZERO;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.timer_control_zero <= `CTM_CTRL0_RST;
         s.timer_control_one <= `CTM_CTRL1_RST;
      end else begin
         s <= next_s;
      end
   end

   // polarity inverts the pin except in timer/counter mode
   assign timer_output_pin = (mode == ctm_pkg::CTM_MODE_TIMER) ? 1'b0 :
      (s.out_level ^ ctl_bit(s.timer_control_one, `CTM_C1_POL));
   assign reg_rdata = s.rd_data;
   assign duty_match_flag = s.duty_match_flag;
   assign period_match_flag = s.period_match_flag;

endmodule

// File: dv/ctm_timer_assertions.sv
`timescale 1ns/1ps
module ctm_timer_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic timer_output_pin,
   input wire logic duty_match_flag,
   input wire logic period_match_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // shadow registers
   // ----------------------------------------
   logic [7:0] c0, c1, gap;
   logic [1:0] dh;
   always_ff @(posedge clk) begin
      if (rst) begin
         c0 <= 8'h00;
         c1 <= 8'h00;
         dh <= 2'h0;
         gap <= 8'hFF;
      end else begin
         c0 <= (reg_wr && reg_addr == 3'h0) ? reg_wdata : c0;
         c1 <= (reg_wr && reg_addr == 3'h1) ? reg_wdata : c1;
         dh <= (reg_wr && reg_addr == 3'h5) ? reg_wdata[1:0] : dh;
         // saturate so a long quiet spell never wraps into a false gap
         gap <= period_match_flag ? 8'h00 : ((gap == 8'hFF) ? gap : gap + 8'h01);
      end
   end
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata not idle");
   rd_unmapped_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   ctrl0_readback_a: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata == c0)
      else $error("ctrl0 readback wrong");
   ctrl1_readback_a: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata == c1)
      else $error("ctrl1 readback wrong");
   duty_high_a: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata == {6'h00, dh})
      else $error("duty high readback wrong");
   cnt_high_a: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[7:2] == 6'h00)
      else $error("counter high has stray bits");
   duty_pulse_a: assert property (duty_match_flag |=> !duty_match_flag)
      else $error("duty flag longer than a pulse");
   period_gap_a: assert property (period_match_flag && gap != 8'hFF |-> gap >= 8'd127)
      else $error("period flags too close");
   cclr_no_period_a: assert property ($past(c1[0]) |-> !period_match_flag)
      else $error("period flag with duty clear");
   timer_pin_a: assert property (c1[7:6] == 2'h3 && $past(c1[7:6]) == 2'h3 |-> !timer_output_pin)
      else $error("pin driven in timer mode");
   run_off_quiet_a: assert property ($past(c0[3]) == 1'b0 |-> !duty_match_flag && !period_match_flag)
      else $error("flag while run bit off");
   reserved_quiet_a: assert property ($past(c0[6:4]) == 3'h5 |-> !duty_match_flag && !period_match_flag)
      else $error("flag with reserved clock");
endmodule

bind ctm_timer ctm_timer_checker ctm_timer_checker_inst (.clk, .rst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .timer_output_pin, .duty_match_flag, .period_match_flag);

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic high_clk_in = 1'b0;
   logic sub_clk_in = 1'b0;
   logic pin = 1'b0;
   logic [7:0] rdata, v, lo;
   logic out_pin, duty_flag, per_flag;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int n, d;
   ctm_timer ctm_timer_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata(rdata), .high_clk_in, .sub_clk_in, .external_clock_pin(pin),
      .timer_output_pin(out_pin), .duty_match_flag(duty_flag), .period_match_flag(per_flag));
   initial forever #5 clk = ~clk;
   always #37 high_clk_in = ~high_clk_in;
   always #61 sub_clk_in = ~sub_clk_in;
   // ----------------------------------------
   // bus access and closing
   // ----------------------------------------
   // strobes drop before the next call so no signal is assigned twice per step
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] dt);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= dt;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask
   task automatic close_out();
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         close_out();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_buffer();
      bus(0, 3'h0, 8'h00);
      `CHK(v, 8'h00)
      bus(1, 3'h1, 8'hC5);
      bus(0, 3'h1, 8'h00);
      `CHK(v, 8'hC5)
      bus(0, 3'h6, 8'h00);
      `CHK(v, 8'h00)
      bus(1, 3'h4, 8'h34);
      bus(1, 3'h5, 8'h01);
      bus(1, 3'h4, 8'h56);
      bus(0, 3'h5, 8'h00);
      `CHK(v, 8'h01)
      bus(0, 3'h4, 8'h00);
      `CHK(v, 8'h34)
      bus(0, 3'h3, 8'h00);
      bus(0, 3'h4, 8'h00);
      `CHK(v, 8'h00)
   endtask
   task automatic t_period();
      bus(1, 3'h1, 8'h00);
      bus(1, 3'h4, 8'h40);
      bus(1, 3'h5, 8'h00);
      for (int k = 0; k < 8; k++) begin
         bus(1, 3'h0, 8'h10 | k[7:0]);
         bus(1, 3'h0, 8'h18 | k[7:0]);
         do @(negedge clk); while (per_flag !== 1'b1);
         n = 0;
         d = 0;
         do begin
            @(negedge clk);
            n++;
            d += (duty_flag === 1'b1);
         end while (per_flag !== 1'b1);
         `CHK(n, (k == 0) ? 1024 : k * 128)
         `CHK(d, 1)
         @(posedge clk);
      end
   endtask
   task automatic t_hold();
      logic [7:0] cfg [3] = '{8'h98, 8'h58, 8'h10};
      foreach (cfg[i]) begin
         bus(1, 3'h0, 8'h18);
         bus(1, 3'h0, cfg[i]);
         bus(0, 3'h3, 8'h00);
         bus(0, 3'h2, 8'h00);
         lo = v;
         bus(0, 3'h3, 8'h00);
         bus(0, 3'h2, 8'h00);
         `CHK(v, lo)
      end
      bus(1, 3'h1, 8'h08);
      bus(1, 3'h0, 8'h18);
      bus(0, 3'h3, 8'h00);
      `CHK(v, 8'h00)
      bus(0, 3'h2, 8'h00);
      `CHK(v < 8'h08, 1'b1)
      `CHK(out_pin, 1'b1)
   endtask
   task automatic t_ext();
      for (int s = 6; s < 8; s++) begin
         bus(1, 3'h0, 8'h00 | (s[7:0] << 4));
         bus(1, 3'h0, 8'h08 | (s[7:0] << 4));
         repeat (5) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
         end
         bus(0, 3'h3, 8'h00);
         bus(0, 3'h2, 8'h00);
         `CHK(v, 8'h05)
      end
   endtask
   // slow sources are free running, so the counts carry a small window
   task automatic t_clocks();
      logic [2:0] sel [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
      int lo_b [4] = '{248, 7, 1, 80};
      int hi_b [4] = '{253, 9, 3, 84};
      foreach (sel[i]) begin
         bus(1, 3'h0, {1'b0, sel[i], 4'h0});
         bus(1, 3'h0, {1'b0, sel[i], 4'h8});
         repeat (1000) @(posedge clk);
         bus(0, 3'h3, 8'h00);
         `CHK(v, 8'h00)
         bus(0, 3'h2, 8'h00);
         `CHK(v >= lo_b[i] && v <= hi_b[i], 1'b1)
      end
   endtask
   // period code 1 would clear at 128 unless the duty clear takes over
   task automatic t_cclr();
      bus(1, 3'h0, 8'h11);
      bus(1, 3'h1, 8'h01);
      bus(1, 3'h4, 8'hFF);
      bus(1, 3'h5, 8'h00);
      bus(1, 3'h0, 8'h19);
      n = 0;
      d = 0;
      repeat (600) begin
         @(negedge clk);
         n += (per_flag === 1'b1);
         d += (duty_flag === 1'b1);
      end
      `CHK(n, 0)
      `CHK(d >= 2, 1'b1)
      bus(0, 3'h3, 8'h00);
      `CHK(v, 8'h00)
      bus(0, 3'h2, 8'h00);
      lo = v;
      bus(0, 3'h2, 8'h00);
      `CHK(v, lo)
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_buffer();
      t_period();
      t_hold();
      t_ext();
      t_clocks();
      t_cclr();
      close_out();
   end
endmodule
